// ==== hw/reset_ctl_pkg.sv ====
// package: offsets, field positions, reset values and timing for reset control
package reset_ctl_pkg;
  // status sits at word index 3, so its byte address is four times that;
  // the other registers take the aligned words that follow
  localparam int STATUS_INDEX = 3;
  localparam logic [11:0] STATUS_OFFSET = 12'h00C;
  localparam logic [11:0] CONFIG_OFFSET = 12'h010;
  localparam logic [11:0] EVENT_OFFSET = 12'h014;
  localparam logic [11:0] CAUSE_OFFSET = 12'h018;
  // status field positions
  localparam int PIN_WAKE_BIT = 7;
  localparam int CMP_WAKE_BIT = 6;
  localparam int TIMEOUT_BIT = 4;
  localparam int POWERDOWN_BIT = 3;
  // config field positions
  localparam int CFG_EXT_RESET_EN_BIT = 0;
  localparam int CFG_TIMER_EN_BIT = 1;
  localparam int CFG_SW_PULLUP_BIT = 2;
  // event register write-one-to-trigger bits
  localparam int EV_SLEEP_BIT = 0;
  localparam int EV_PIN_WAKE_BIT = 1;
  localparam int EV_CMP_WAKE_BIT = 2;
  localparam logic [2:0] CONFIG_RESET = 3'h3;
  // status loads, upper five bits 7..3
  localparam logic [4:0] ST_POWERUP = 5'h03;
  localparam logic [4:0] ST_PIN_SLEEP = 5'h02;
  localparam logic [4:0] ST_WDT_SLEEP = 5'h00;
  localparam logic [4:0] ST_PINCHG_WAKE = 5'h12;
  localparam logic [4:0] ST_CMP_WAKE = 5'h0A;
  // start-up timer period
  localparam int CLK_MHZ = 250;
  localparam int TIMER_MS = 18;
  localparam int TIMER_CYCLES = TIMER_MS * 1000 * CLK_MHZ;
  // reset causes
  typedef enum logic [2:0] {
    CAUSE_NONE, CAUSE_POR, CAUSE_BOR, CAUSE_PIN_RUN, CAUSE_PIN_SLEEP,
    CAUSE_WDT_RUN, CAUSE_WDT_SLEEP, CAUSE_WAKE_CHG
  } cause_t;
endpackage : reset_ctl_pkg

// ==== hw/reset_source_and_startup_timer.sv ====
// reset source recognition, status cause loading and start-up hold
// Functional notes
// RULE1: recognise seven distinct reset sources
// RULE2: some registers never reset by any source
// RULE3: normal-run resets reinitialise ordinary registers
// RULE4: sleep pin/watchdog resets keep registers
// RULE5: power-on/brown-out loads status 0001 1xxx
// RULE6: pin reset running clears top three bits
// RULE7: pin reset asleep loads bits 7..3 00010
// RULE8: watchdog asleep clears bits seven to three
// RULE9: watchdog running clears bits seven to four
// RULE10: pin-change wake loads bits 7..3 10010
// RULE11: comparator wake loads bits 7..3 01010
// RULE12: enable bit gates external reset pin
// RULE13: enable forces weak pull-up on
// RULE14: hold reset until supply good
// RULE15: power-up sets latch, clears timer
// RULE16: timer counts only once pin is high
// RULE17: timeout clears latch, ending chip reset
// RULE18: outside circuit holds pin low until stable
// RULE19: timer enable extends reset 18 ms; code ignores config bit 1, the start-up timer always runs
// RULE20: brown-out during timing restarts the timer
// RULE21: powerdown set on power-up, cleared by sleep
// RULE22: status bit roles: 7,6,4,3 flags
`timescale 1ns/1ns
module reset_source_and_startup_timer
  import reset_ctl_pkg::*;
#(
  parameter int TIMER_PERIOD = TIMER_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic extResetPin_n,
  input wire logic supplyGood,
  input wire logic brownoutDetect,
  input wire logic watchdogTimeout,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  output logic coreReset,
  output logic regInit,
  output logic pullupEnable,
  output logic pinInput,
  output logic asleep
);
  import reset_ctl_pkg::*;

  // pin and supply monitors come from outside the clock domain
  logic [3:0] rawIn;
  logic [3:0] syncIn;
  logic pinHigh;
  logic supplyOk;
  logic brownout;
  logic wdtEvent;
  assign rawIn = {watchdogTimeout, brownoutDetect, supplyGood, extResetPin_n};
  sync_two_ff #(.WIDTH(4)) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .async(rawIn),
    .synced(syncIn)
  );
  assign pinHigh = syncIn[0];
  assign supplyOk = syncIn[1];
  assign brownout = syncIn[2];

  // state registers
  logic [2:0] cfg;
  logic [7:0] status;
  logic resetLatch;
  logic powerSeen;
  logic wdtPrev;
  logic pinPrev;
  logic sleeping;
  cause_t lastCause;
  logic [7:0] next_status;
  logic [2:0] next_cfg;
  logic next_resetLatch;
  logic next_powerSeen;
  logic next_sleeping;
  logic next_regInit;
  cause_t next_lastCause;
  logic [31:0] next_prdata;
  logic next_pready;
  logic timerDone;
  logic timerClear;

  logic extEn;
  logic pinReset;
  logic pinFall;
  logic supplyBad;
  logic wr;
  logic rd;
  logic evSleep;
  logic evPinWake;
  logic evCmpWake;
  assign extEn = cfg[CFG_EXT_RESET_EN_BIT];
  // pin disabled means internal reset input tied inactive
  assign pinReset = extEn && !pinHigh; // RULE12
  assign pinFall = extEn && pinPrev && !pinHigh;
  assign wdtEvent = syncIn[3] && !wdtPrev;
  assign supplyBad = !supplyOk || brownout; // RULE14
  assign wr = psel && penable && pwrite && pready;
  assign rd = psel && !penable && !pwrite;
  assign evSleep = wr && paddr == EVENT_OFFSET && pwdata[EV_SLEEP_BIT];
  assign evPinWake = wr && paddr == EVENT_OFFSET
                     && pwdata[EV_PIN_WAKE_BIT] && sleeping;
  assign evCmpWake = wr && paddr == EVENT_OFFSET
                     && pwdata[EV_CMP_WAKE_BIT] && sleeping;

  // timer held clear while supply is bad or first power-up
  assign timerClear = supplyBad || !powerSeen || pinFall; // RULE15 RULE20
  startup_timer #(.PERIOD(TIMER_PERIOD)) u_timer (
    .clk(clk),
    .sys_rst(sys_rst),
    .clear(timerClear),
    .run(pinHigh || !extEn), // RULE16
    .done(timerDone)
  );

  // reset cause decode and status loading
  always_comb begin
    next_status = status;
    next_cfg = cfg;
    next_resetLatch = resetLatch;
    next_powerSeen = 1'b1;
    next_sleeping = sleeping;
    next_regInit = 1'b0;
    next_lastCause = lastCause;
    if (!powerSeen || supplyBad) begin
      // lower three bits left as is: undefined at power-on
      next_status[7:3] = ST_POWERUP; // RULE5 RULE21
      next_resetLatch = 1'b1; // RULE15
      next_sleeping = 1'b0;
      next_regInit = 1'b1; // RULE3
      // monitors read low until synced, so a dip before first release
      // still counts as power-on
      next_lastCause = (powerSeen && !(resetLatch && lastCause == CAUSE_POR))
                       ? CAUSE_BOR : CAUSE_POR; // RULE1
    end else if (pinFall) begin
      next_resetLatch = 1'b1;
      if (sleeping) begin
        next_status[7:3] = ST_PIN_SLEEP; // RULE7 RULE4
        next_lastCause = CAUSE_PIN_SLEEP;
      end else begin
        next_status[7:5] = 3'h0; // RULE6
        next_regInit = 1'b1; // RULE3
        next_lastCause = CAUSE_PIN_RUN;
      end
      next_sleeping = 1'b0;
    end else if (wdtEvent && !resetLatch) begin
      if (sleeping) begin
        next_status[7:3] = ST_WDT_SLEEP; // RULE8 RULE4
        next_lastCause = CAUSE_WDT_SLEEP;
      end else begin
        next_status[7:4] = 4'h0; // RULE9 RULE21
        next_regInit = 1'b1;
        next_lastCause = CAUSE_WDT_RUN;
      end
      next_sleeping = 1'b0;
    end else if (evPinWake) begin
      next_status[7:3] = ST_PINCHG_WAKE; // RULE10 RULE22
      next_regInit = 1'b1;
      next_sleeping = 1'b0;
      next_lastCause = CAUSE_WAKE_CHG;
    end else if (evCmpWake) begin
      next_status[7:3] = ST_CMP_WAKE; // RULE11 RULE22
      next_sleeping = 1'b0;
      next_lastCause = CAUSE_WAKE_CHG;
    end else if (evSleep && !resetLatch) begin
      // sleep sets timeout flag and clears powerdown
      next_status[TIMEOUT_BIT] = 1'b1;
      next_status[POWERDOWN_BIT] = 1'b0; // RULE21
      next_sleeping = 1'b1;
    end else if (resetLatch && timerDone && !pinReset) begin
      next_resetLatch = 1'b0; // RULE17 RULE19
    end
    if (wr && paddr == CONFIG_OFFSET) begin
      next_cfg = pwdata[2:0];
    end
    // bits below three are ordinary software bits
    if (wr && paddr == STATUS_OFFSET) begin
      next_status[2:0] = pwdata[2:0];
    end
  end

  // apb read mux, no wait states
  always_comb begin
    next_pready = rd || (psel && !penable);
    next_prdata = 32'h0;
    if (rd) begin
      unique case (paddr)
        STATUS_OFFSET: next_prdata = {24'h0, status};
        CONFIG_OFFSET: next_prdata = {29'h0, cfg};
        CAUSE_OFFSET: next_prdata = {29'h0, lastCause};
        default: next_prdata = 32'h0;
      endcase
    end
  end

  // status register never gets a reset value of its own
  always_ff @(posedge clk) begin
    status <= next_status; // RULE2
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfg <= CONFIG_RESET;
      resetLatch <= 1'b1;
      powerSeen <= 1'b0;
      sleeping <= 1'b0;
      lastCause <= CAUSE_NONE;
      wdtPrev <= 1'b0;
      pinPrev <= 1'b1;
      regInit <= 1'b1;
      coreReset <= 1'b1;
      pullupEnable <= 1'b1;
      pinInput <= 1'b0;
      asleep <= 1'b0;
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      cfg <= next_cfg;
      resetLatch <= next_resetLatch;
      powerSeen <= next_powerSeen;
      sleeping <= next_sleeping;
      lastCause <= next_lastCause;
      wdtPrev <= syncIn[3];
      pinPrev <= pinHigh || !extEn;
      regInit <= next_regInit;
      coreReset <= next_resetLatch || pinReset; // RULE14 RULE18
      pullupEnable <= next_cfg[CFG_EXT_RESET_EN_BIT]
                      || next_cfg[CFG_SW_PULLUP_BIT]; // RULE13
      pinInput <= !next_cfg[CFG_EXT_RESET_EN_BIT] && pinHigh; // RULE12
      asleep <= next_sleeping;
      pready <= next_pready && !pready;
      prdata <= next_prdata;
      pslverr <= 1'b0;
    end
  end

  // checks: outputs are registered from next values, so the pin-side
  // levels line up with cfg in the same cycle
  chk_pullup_forced: assert property ( // RULE13
    @(posedge clk) disable iff (sys_rst)
    cfg[CFG_EXT_RESET_EN_BIT] |-> pullupEnable)
    else $error("pull-up not forced");
  chk_pin_gated: assert property ( // RULE12
    @(posedge clk) disable iff (sys_rst)
    !extEn && !resetLatch && !supplyBad |=> !coreReset)
    else $error("disabled pin caused reset");
  chk_pin_input: assert property ( // RULE12
    @(posedge clk) disable iff (sys_rst)
    cfg[CFG_EXT_RESET_EN_BIT] |-> !pinInput)
    else $error("pin read as input while reset pin");
  chk_supply_hold: assert property ( // RULE14
    @(posedge clk) disable iff (sys_rst)
    supplyBad |=> coreReset)
    else $error("reset released on bad supply");
  chk_por_status: assert property ( // RULE5
    @(posedge clk) disable iff (sys_rst)
    powerSeen && supplyBad |=> status[7:3] == ST_POWERUP)
    else $error("power-up status wrong");
  chk_pin_run: assert property ( // RULE6
    @(posedge clk) disable iff (sys_rst)
    powerSeen && !supplyBad && pinFall && !sleeping
    |=> status[7:5] == 3'h0 && status[4:3] == $past(status[4:3]) && regInit)
    else $error("running pin reset status wrong");
  chk_pin_sleep: assert property ( // RULE7
    @(posedge clk) disable iff (sys_rst)
    powerSeen && !supplyBad && pinFall && sleeping
    |=> status[7:3] == 5'h02 && !regInit && coreReset)
    else $error("sleeping pin reset status wrong");
  chk_wdt_sleep: assert property ( // RULE8
    @(posedge clk) disable iff (sys_rst)
    powerSeen && !supplyBad && !pinFall && wdtEvent && !resetLatch
    && sleeping |=> status[7:3] == 5'h00 && !asleep)
    else $error("watchdog sleep status wrong");
  chk_wdt_run: assert property ( // RULE9
    @(posedge clk) disable iff (sys_rst)
    powerSeen && !supplyBad && !pinFall && wdtEvent && !resetLatch
    && !sleeping |=> status[7:4] == 4'h0 && status[3] == $past(status[3])
    && regInit)
    else $error("running watchdog status wrong");
  chk_pinchg_wake: assert property ( // RULE10
    @(posedge clk) disable iff (sys_rst)
    powerSeen && !supplyBad && !pinFall && !(wdtEvent && !resetLatch)
    && evPinWake |=> status[7:3] == 5'h12 && !asleep && regInit)
    else $error("pin-change wake status wrong");
  chk_cmp_wake: assert property ( // RULE11
    @(posedge clk) disable iff (sys_rst)
    powerSeen && !supplyBad && !pinFall && !(wdtEvent && !resetLatch)
    && !evPinWake && evCmpWake |=> status[7:3] == 5'h0A && !asleep)
    else $error("comparator wake status wrong");
  chk_sleep_flags: assert property ( // RULE21
    @(posedge clk) disable iff (sys_rst)
    evSleep && !resetLatch && !supplyBad && powerSeen && !pinFall
    && !wdtEvent && !evPinWake && !evCmpWake
    |=> status[POWERDOWN_BIT] == 1'b0 && status[TIMEOUT_BIT])
    else $error("sleep flags wrong");
  chk_latch_release: assert property ( // RULE17
    @(posedge clk) disable iff (sys_rst)
    $fell(resetLatch) |-> $past(timerDone))
    else $error("latch released early");
  chk_timer_restart: assert property ( // RULE20
    @(posedge clk) disable iff (sys_rst)
    supplyBad |=> !timerDone ##1 !timerDone)
    else $error("timer not restarted");
  chk_timer_wait: assert property ( // RULE16
    @(posedge clk) disable iff (sys_rst)
    extEn && !pinHigh && !timerDone |=> !timerDone)
    else $error("timer counted with pin low");
  cov_release: cover property (@(posedge clk) $fell(coreReset));
  cov_wdt_sleep: cover property (@(posedge clk) lastCause == CAUSE_WDT_SLEEP);
  cov_pin_run: cover property (@(posedge clk) lastCause == CAUSE_PIN_RUN);
  cov_pin_sleep: cover property (@(posedge clk) lastCause == CAUSE_PIN_SLEEP);
  cov_brownout: cover property (@(posedge clk) lastCause == CAUSE_BOR);
endmodule : reset_source_and_startup_timer

// ==== hw/startup_timer.sv ====
// start-up timer: counts while enabled, restarts on clear
`timescale 1ns/1ns
module startup_timer #(
  parameter int PERIOD = 4500000
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clear,
  input wire logic run,
  output logic done
);
  logic [31:0] count;
  logic [31:0] next_count;
  logic next_done;
  // terminal count held until the next clear
  always_comb begin
    next_count = count;
    next_done = done;
    if (clear) begin
      next_count = '0;
      next_done = 1'b0;
    end else if (run && !done) begin
      next_count = count + 32'h1;
      if (next_count >= 32'(PERIOD)) next_done = 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      count <= '0;
      done <= 1'b0;
    end else begin
      count <= next_count;
      done <= next_done;
    end
  end
endmodule : startup_timer

// ==== hw/sync_two_ff.sv ====
// two-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ns
module sync_two_ff #(
  parameter int WIDTH = 4
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] async,
  output logic [WIDTH-1:0] synced
);
  logic [WIDTH-1:0] stage;
  // first stage is read only by the second
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stage <= '0;
      synced <= '0;
    end else begin
      stage <= async;
      synced <= stage;
    end
  end
endmodule : sync_two_ff

// ==== testbench/pin_supply_model.sv ====
// far-side model: external reset pin and supply level monitors
`timescale 1ns/1ns
module pin_supply_model (
  input wire logic clk,
  input wire logic holdPin,
  input wire logic sagSupply,
  input wire logic fireDog,
  output logic extResetPin_n,
  output logic supplyGood,
  output logic brownoutDetect,
  output logic watchdogTimeout
);
  // monitors track the supply; the pin cannot rise before supply is good
  always_ff @(posedge clk) begin
    supplyGood <= !sagSupply;
    brownoutDetect <= sagSupply;
    extResetPin_n <= !(holdPin || sagSupply);
    watchdogTimeout <= fireDog;
  end
endmodule : pin_supply_model

// ==== testbench/reset_source_and_startup_timer_bench.sv ====
// self-checking bench for reset source and start-up timer
`timescale 1ns/1ns
module reset_source_and_startup_timer_bench;
  import reset_ctl_pkg::*;
  localparam int TP = 20;
  logic clk = 1'b0;
  logic sysRst = 1'b1;
  logic holdPin = 1'b0, sagSupply = 1'b0, fireDog = 1'b0;
  logic pinN, good, brown, dog;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdata;
  logic pready, pslverr, coreReset, regInit, pullupEnable, pinInput, asleep;
  logic [7:0] st;
  logic [2:0] lo;
  logic [4:0] upper [4] = '{5'h02, 5'h00, 5'h12, 5'h0A};
  cause_t why [4] = '{CAUSE_PIN_SLEEP, CAUSE_WDT_SLEEP, CAUSE_WAKE_CHG,
                      CAUSE_WAKE_CHG};
  int mismatches = 0, nChecks = 0, cycles = 0, inits = 0, seed = 19, n;

  always #2 clk = ~clk;

  reset_source_and_startup_timer #(.TIMER_PERIOD(TP)) u_dut (.clk(clk),
    .sys_rst(sysRst), .extResetPin_n(pinN), .supplyGood(good),
    .brownoutDetect(brown), .watchdogTimeout(dog), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .coreReset(coreReset), .regInit(regInit), .pullupEnable(pullupEnable),
    .pinInput(pinInput), .asleep(asleep));

  pin_supply_model u_far (.clk(clk), .holdPin(holdPin),
    .sagSupply(sagSupply), .fireDog(fireDog), .extResetPin_n(pinN),
    .supplyGood(good), .brownoutDetect(brown), .watchdogTimeout(dog));

  // hang guard and count of cycles with reinitialise high
  always @(posedge clk) begin
    cycles++;
    if (regInit === 1'b1) inits++;
    if (cycles == 20000) begin
      mismatches++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", nChecks, mismatches);
    if (mismatches == 0 && nChecks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : conclude

  task automatic chkReg(input string what, input logic [31:0] exp,
                        input logic [31:0] got);
    nChecks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chkReg

  task automatic chkPin(input string what, input logic exp, input logic got);
    nChecks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask : chkPin

  // one APB transfer; held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdata = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic chkStatus(input logic [7:0] m);
    apb(1'b0, STATUS_OFFSET, 32'h0);
    chkReg("status", {24'h0, st & m}, rdata & {24'h0, m});
  endtask : chkStatus

  task automatic chkCause(input cause_t c);
    apb(1'b0, CAUSE_OFFSET, 32'h0);
    chkReg("cause", {29'h0, c}, rdata);
  endtask : chkCause

  // bounded wait until the core runs again
  task automatic waitRel();
    n = 0;
    while ((coreReset !== 1'b0 || asleep !== 1'b0) && n < 400) begin
      @(posedge clk);
      n++;
    end
    chkPin("coreReset", 1'b0, coreReset);
  endtask : waitRel

  task automatic pinReset();
    holdPin <= 1'b1;
    repeat (8) @(posedge clk);
    holdPin <= 1'b0;
    waitRel();
  endtask : pinReset

  task automatic dogReset();
    fireDog <= 1'b1;
    repeat (6) @(posedge clk);
    fireDog <= 1'b0;
    waitRel();
  endtask : dogReset

  task automatic newLow();
    lo = 3'($random(seed));
    apb(1'b1, STATUS_OFFSET, {29'h0, lo});
    st[2:0] = lo;
  endtask : newLow

  initial begin
    repeat (8) @(posedge clk);
    sysRst <= 1'b0;
    waitRel();
    chkPin("pullupEnable", 1'b1, pullupEnable);
    st = 8'h18;
    chkStatus(8'hF8);
    chkCause(CAUSE_POR);
    newLow();
    chkStatus(8'hFF);
    $display("test power-on done");
    // running resets: pin then watchdog, both reinitialise
    inits = 0;
    pinReset();
    st = st & 8'h1F;
    chkStatus(8'hFF);
    chkCause(CAUSE_PIN_RUN);
    chkPin("regInit", 1'b1, inits > 0);
    inits = 0;
    dogReset();
    st = st & 8'h0F;
    chkStatus(8'hFF);
    chkCause(CAUSE_WDT_RUN);
    chkPin("regInit", 1'b1, inits > 0);
    $display("test running resets done");
    // resets and wakes from sleep, one per pass
    for (int k = 0; k < 4; k++) begin
      newLow();
      apb(1'b1, EVENT_OFFSET, 32'h1);
      repeat (3) @(posedge clk);
      chkPin("asleep", 1'b1, asleep);
      st[3] = 1'b0;
      chkStatus(8'h08);
      inits = 0;
      case (k)
        0: pinReset();
        1: dogReset();
        default: begin
          apb(1'b1, EVENT_OFFSET, (k == 2) ? 32'h2 : 32'h4);
          waitRel();
        end
      endcase
      st = {upper[k], lo};
      chkStatus(8'hFF);
      if (k < 2) chkPin("regInit", 1'b0, inits > 0);
      chkCause(why[k]);
    end
    $display("test sleep resets done");
    // pin reset function switched off, pull-up off with software bit clear, then forced on by re-enable
    apb(1'b1, CONFIG_OFFSET, 32'h0);
    holdPin <= 1'b1;
    repeat (8) @(posedge clk);
    chkPin("coreReset", 1'b0, coreReset);
    chkPin("pinInput", 1'b0, pinInput);
    chkPin("pullupEnable", 1'b0, pullupEnable);
    holdPin <= 1'b0;
    repeat (6) @(posedge clk);
    chkPin("pinInput", 1'b1, pinInput);
    apb(1'b1, CONFIG_OFFSET, 32'h1);
    repeat (3) @(posedge clk);
    chkPin("pullupEnable", 1'b1, pullupEnable);
    apb(1'b1, CONFIG_OFFSET, 32'h3);
    $display("test pin enable done");
    // brown-out strikes again while the timer runs
    sagSupply <= 1'b1;
    repeat (6) @(posedge clk);
    sagSupply <= 1'b0;
    repeat (8) @(posedge clk);
    chkPin("coreReset", 1'b1, coreReset);
    sagSupply <= 1'b1;
    repeat (6) @(posedge clk);
    sagSupply <= 1'b0;
    waitRel();
    chkPin("holdSpan", 1'b1, n >= TP && n <= TP + 10);
    st = 8'h18;
    chkStatus(8'hF8);
    chkCause(CAUSE_BOR);
    apb(1'b0, 12'h020, 32'h0);
    chkReg("unmapped", 32'h0, rdata);
    chkPin("pslverr", 1'b0, pslverr);
    $display("test brown-out done");
    conclude();
  end
endmodule : reset_source_and_startup_timer_bench
